// File: design/fspp_device.sv
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
// Protection, addressing and page programming of the on-chip flash
module fspp_device
    import fspp_pkg::*;
#(
    parameter int PW        = 3,  // Word-in-page address bits
    parameter int PGB       = 3,  // Page number bits
    parameter int BOOT_PAGE = 6   // First page of the boot section
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    fspp_if.dev             lnk,
    input  wire logic       ext_lock_we,
    input  wire logic [5:0] ext_lock_data,
    input  wire logic       ext_fuse_we,
    input  wire logic       ext_fuse_data,
    input  wire logic       chip_erase,
    output logic [5:0]      lock_bits,
    output logic            boot_reset_fuse
);
    localparam int WORDS = 1 << (PW + PGB);
    localparam int PWDS  = 1 << PW;

    typedef enum logic [0:0] {
        D_IDLE = 1'b0,
        D_PROG = 1'b1
    } fspp_dst_t;

    typedef struct packed {
        fspp_dst_t                  st;
        logic [PROG_CW-1:0]         cnt;
        logic                       erase;     // Latched kind of programming
        logic [PGB-1:0]             page;      // Latched page number
        logic [PWDS-1:0][15:0]      buf_w;     // Temporary page buffer
        logic [WORDS-1:0][15:0]     flash;
        logic [5:0]                 lock;
        logic                       fuse;
        logic                       done;
        logic                       denied;
        logic [7:0]                 rdata;
        logic                       irq_blk;
    } fspp_dev_t;

    localparam fspp_dev_t DEV_RST = '{
        st:      D_IDLE,
        cnt:     '0,
        erase:   1'b0,
        page:    '0,
        buf_w:   {PWDS{ERASED_WORD}},
        flash:   {WORDS{ERASED_WORD}},
        lock:    LOCK_RST,
        fuse:    FUSE_RST,
        done:    1'b0,
        denied:  1'b0,
        rdata:   8'h00,
        irq_blk: 1'b0
    };

    fspp_dev_t s_q;
    fspp_dev_t s_d;

    logic [15:0]     ptr;
    logic [PW-1:0]   widx;
    logic [PGB-1:0]  pg;
    logic            tgt_boot;
    logic            app_wblk;
    logic            app_rblk;
    logic            app_irqm;
    logic            boot_wblk;
    logic            boot_rblk;
    logic            boot_irqm;
    logic            wr_blocked;
    logic            rd_blocked;
    logic [15:0]     rd_word;

    // Pointer split: bit 0 byte, then word index, then page
    assign ptr      = {lnk.pointer_high_byte, lnk.pointer_low_byte};  // see R11
    assign widx     = ptr[PW:1];                                      // see R12
    assign pg       = ptr[PW+PGB:PW+1];                               // see R12
    assign tgt_boot = (pg >= PGB'(BOOT_PAGE));
    assign rd_word  = s_q.flash[{pg, widx}];

    // Lock bits one and two (the general locks) are never looked at here
    fspp_prot_decode u_app (
        .hi       (s_q.lock[APP_HI_POS]),
        .lo       (s_q.lock[APP_LO_POS]),
        .wr_block (app_wblk),
        .rd_block (app_rblk),
        .irq_mode (app_irqm)
    );  // see R2 see R3

    fspp_prot_decode u_boot (
        .hi       (s_q.lock[BOOT_HI_POS]),
        .lo       (s_q.lock[BOOT_LO_POS]),
        .wr_block (boot_wblk),
        .rd_block (boot_rblk),
        .irq_mode (boot_irqm)
    );

    // Store protection follows the target section only
    assign wr_blocked = tgt_boot ? boot_wblk : app_wblk;  // see R4 see R6
    // Load protection only applies when reading across sections
    assign rd_blocked = tgt_boot ? (boot_rblk & ~lnk.exec_boot)
                                 : (app_rblk & lnk.exec_boot);  // see R4 see R6

    // Next-state logic for the whole block
    always_comb begin
        s_d        = s_q;
        s_d.done   = 1'b0;
        s_d.denied = 1'b0;
        // Mask when running from the section away from the vectors
        s_d.irq_blk = (app_irqm & lnk.ivec_boot & ~lnk.exec_boot)
                    | (boot_irqm & ~lnk.ivec_boot & lnk.exec_boot);  // see R5 see R7
        unique case (s_q.st)
            D_IDLE: begin
                if (lnk.req_valid) begin
                    s_d.done = 1'b1;
                    unique case (lnk.op)
                        OP_BUF: begin
                            // Any word of the buffer may be written in any order, but only while executing from the boot section
                            if (!lnk.exec_boot) begin
                                s_d.denied = 1'b1;        // see R21
                            end else begin
                                s_d.buf_w[widx] = lnk.wdata;  // see R17 see R18
                            end
                        end
                        OP_ERASE, OP_WRITE: begin
                            if (!lnk.exec_boot || wr_blocked) begin
                                s_d.denied = 1'b1;        // see R21 see R22
                            end else begin
                                // Page is captured so the pointer is free again
                                s_d.done  = 1'b0;
                                s_d.st    = D_PROG;
                                s_d.erase = (lnk.op == OP_ERASE);
                                s_d.page  = pg;                        // see R13
                                s_d.cnt   = PROG_CW'(PROG_CYC - 1);
                            end
                        end
                        OP_LOCK: begin
                            // Pointer plays no part; software may only program bits
                            if (!lnk.exec_boot) begin
                                s_d.denied = 1'b1;        // see R21
                            end else begin
                                s_d.lock = s_q.lock & lnk.wdata[5:0];  // see R1 see R14
                            end
                        end
                        OP_LOAD: begin
                            if (rd_blocked) begin
                                s_d.denied = 1'b1;
                                s_d.rdata  = 8'h00;       // see R22
                            end else begin
                                s_d.rdata = ptr[0] ? rd_word[15:8] : rd_word[7:0];  // see R15
                            end
                        end
                        default: begin
                            s_d.denied = 1'b1;
                        end
                    endcase
                end
            end
            D_PROG: begin
                if (s_q.cnt != '0) begin
                    s_d.cnt = s_q.cnt - PROG_CW'(1);
                end else begin
                    // Writing only clears bits, so an unerased page ends up corrupt
                    for (int i = 0; i < PWDS; i++) begin
                        if (s_q.erase) begin
                            s_d.flash[{s_q.page, PW'(i)}] = ERASED_WORD;
                        end else begin
                            s_d.flash[{s_q.page, PW'(i)}] =
                                s_q.flash[{s_q.page, PW'(i)}] & s_q.buf_w[i];  // see R17
                        end
                    end
                    // Buffer empties itself after a page write
                    if (!s_q.erase) begin
                        s_d.buf_w = {PWDS{ERASED_WORD}};
                    end
                    s_d.st   = D_IDLE;
                    s_d.done = 1'b1;
                end
            end
        endcase
        // External programming: locks only programmed, fuse either way
        if (ext_lock_we) begin
            s_d.lock = s_d.lock & ext_lock_data;   // see R1
        end
        if (ext_fuse_we) begin
            s_d.fuse = ext_fuse_data;              // see R10
        end
        // Chip erase and reset are the only ways back to unprogrammed locks
        if (chip_erase) begin
            s_d.lock  = LOCK_RST;                  // see R1
            s_d.flash = {WORDS{ERASED_WORD}};
            s_d.buf_w = {PWDS{ERASED_WORD}};
            s_d.st    = D_IDLE;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= DEV_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs
    assign lnk.req_ready  = (s_q.st == D_IDLE);
    assign lnk.done       = s_q.done;
    assign lnk.denied     = s_q.denied;
    assign lnk.rdata      = s_q.rdata;
    assign lnk.irq_block  = s_q.irq_blk;
    assign lnk.prog_busy  = (s_q.st == D_PROG);
    // Programmed fuse (0) moves reset to the first boot word
    assign lnk.reset_vec  = s_q.fuse ? APP_RESET_ADDR
                                     : 16'(BOOT_PAGE << PW);  // see R8 see R9
    assign lock_bits       = s_q.lock;
    assign boot_reset_fuse = s_q.fuse;

endmodule

// File: design/fspp_host.sv
`timescale 1ns/100ps
// CPU-side controller: software drives self-programming over APB
module fspp_host
    import fspp_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    fspp_if.host             lnk
);
    typedef struct packed {
        fspp_op_t    op;
        logic        req;
        logic        busy;
        logic        denied;
        logic        done;
        logic [7:0]  rdata;
        logic [15:0] ptr;
        logic [15:0] wdata;
        logic        exec_boot;
        logic        ivec_boot;
        logic        started;
        logic [31:0] prdata;
        logic        err;
    } fspp_host_t;

    localparam fspp_host_t HOST_RST = '{
        op: OP_BUF, req: 1'b0, busy: 1'b0, denied: 1'b0, done: 1'b0,
        rdata: 8'h00, ptr: 16'h0000, wdata: 16'h0000, exec_boot: 1'b0,
        ivec_boot: 1'b0, started: 1'b0, prdata: 32'h00000000, err: 1'b0
    };

    fspp_host_t s_q;
    fspp_host_t s_d;
    logic       setup;
    logic       access;
    logic       mapped;

    assign setup  = psel & ~penable;
    assign access = psel & penable;
    assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_PTR) || (paddr == OFS_DATA)
                 || (paddr == OFS_MODE) || (paddr == OFS_STATUS) || (paddr == OFS_RESETV);

    always_comb begin
        s_d = s_q;
        // First edge after reset: start where the reset vector points
        if (!s_q.started) begin
            s_d.started   = 1'b1;
            s_d.exec_boot = (lnk.reset_vec != APP_RESET_ADDR);  // see R20
        end
        // Read data and error are captured in the setup cycle
        if (setup) begin
            s_d.err    = ~mapped;
            s_d.prdata = 32'h00000000;
            if (!pwrite) begin
                unique case (paddr)
                    OFS_CTRL:   s_d.prdata = {29'h0, s_q.op};
                    OFS_PTR:    s_d.prdata = {16'h0, s_q.ptr};
                    OFS_DATA:   s_d.prdata = {16'h0, s_q.wdata};
                    OFS_MODE:   s_d.prdata = {30'h0, s_q.ivec_boot, s_q.exec_boot};
                    OFS_STATUS: begin
                        s_d.prdata[ST_BUSY_POS]  = s_q.busy;
                        s_d.prdata[ST_DEN_POS]   = s_q.denied;
                        s_d.prdata[ST_DONE_POS]  = s_q.done;
                        s_d.prdata[ST_IRQ_POS]   = lnk.irq_block;
                        s_d.prdata[ST_PBUSY_POS] = lnk.prog_busy;
                        s_d.prdata[ST_RDATA_POS +: 8] = s_q.rdata;
                    end
                    OFS_RESETV: s_d.prdata = {16'h0, lnk.reset_vec};
                    default:    s_d.prdata = 32'h00000000;
                endcase
            end
        end
        // Writes take effect at the access edge
        if (access && pwrite) begin
            unique case (paddr)
                OFS_CTRL: begin
                    // Ignored while busy or for unknown codes
                    if (pwdata[CTRL_GO_POS] && !s_q.busy && pwdata[2:0] <= OP_LOAD) begin
                        s_d.op     = fspp_op_t'(pwdata[2:0]);
                        s_d.req    = 1'b1;
                        s_d.busy   = 1'b1;
                        s_d.done   = 1'b0;
                        s_d.denied = 1'b0;
                    end
                end
                // Erase and write both take their page from this one pointer
                OFS_PTR:  s_d.ptr = pwdata[15:0];  // see R16 see R19
                OFS_DATA: s_d.wdata = pwdata[15:0];
                OFS_MODE: begin
                    s_d.exec_boot = pwdata[MODE_EXEC_POS];  // see R20
                    s_d.ivec_boot = pwdata[MODE_IVEC_POS];
                end
                default: begin
                end
            endcase
        end
        if (s_q.req && lnk.req_ready) begin
            s_d.req = 1'b0;
        end
        // Completion sets status; it cannot coincide with a new command
        if (lnk.done && s_q.busy && !s_q.req) begin
            s_d.busy   = 1'b0;
            s_d.done   = 1'b1;
            s_d.denied = lnk.denied;
            s_d.rdata  = lnk.rdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= HOST_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign pready                = access;
    assign prdata                = s_q.prdata;
    assign pslverr               = access & s_q.err;
    assign lnk.req_valid         = s_q.req;
    assign lnk.op                = s_q.op;
    assign lnk.pointer_high_byte = s_q.ptr[15:8];  // see R11
    assign lnk.pointer_low_byte  = s_q.ptr[7:0];
    assign lnk.wdata             = s_q.wdata;
    assign lnk.exec_boot         = s_q.exec_boot;
    assign lnk.ivec_boot         = s_q.ivec_boot;

endmodule

// File: design/fspp_if.sv
`timescale 1ns/100ps
// Link between the CPU-side controller and the protection block
interface fspp_if;
    import fspp_pkg::*;

    logic        req_valid;   // Operation request, held until taken
    logic        req_ready;   // Block idle, request taken
    fspp_op_t    op;          // Operation code
    logic [7:0]  pointer_high_byte;
    logic [7:0]  pointer_low_byte;
    logic [15:0] wdata;       // Word to store, or lock byte in low bits
    logic        exec_boot;   // CPU executes from the boot section
    logic        ivec_boot;   // Interrupt vectors sit in boot section
    logic        done;        // One-cycle completion pulse
    logic        denied;      // With done: operation was blocked
    logic [7:0]  rdata;       // Load result, valid with done
    logic        irq_block;   // Interrupts masked
    logic        prog_busy;   // Erase or write in progress
    logic [15:0] reset_vec;   // Word address of the reset vector

    modport dev (
        input  req_valid, op, pointer_high_byte, pointer_low_byte, wdata, exec_boot, ivec_boot,
        output req_ready, done, denied, rdata, irq_block, prog_busy, reset_vec
    );

    modport host (
        output req_valid, op, pointer_high_byte, pointer_low_byte, wdata, exec_boot, ivec_boot,
        input  req_ready, done, denied, rdata, irq_block, prog_busy, reset_vec
    );
endinterface

// File: design/fspp_pkg.sv
// Summary of operation
// R1 - Lock bits program anywhere, clear by chip erase
// R2 - Write-lock mode 2 never gates load
// R3 - Read/write-lock mode 1 never gates load/store
// R4 - Application field: 11 free, 10 nowrite, 00 both, 01 noread
// R5 - App modes 3/4 mask interrupts running application
// R6 - Boot field: 11 free, 10 nowrite, 00 both, 01 noread
// R7 - Boot modes 3/4 mask interrupts running boot
// R8 - Stored 1 unprogrammed, 0 programmed
// R9 - Reset vector: fuse 1 zero, 0 boot start
// R10 - CPU can never alter any fuse
// R11 - Address comes from sixteen-bit high/low pointer
// R12 - Low word bits index page, high bits page
// R13 - Address latched when programming starts
// R14 - Lock-set operation ignores the pointer
// R15 - Load addresses bytes, pointer bit zero selects
// R16 - Software uses same page for erase, write
// R17 - Erase page before writing it from buffer
// R18 - Page buffer words load in any order
// R19 - Software saves unchanged words across erase
// R20 - Boot entered by jump unless fuse redirects reset
// R21 - Store disabled while executing application section
// R22 - Blocked access changes nothing, returns no data
package fspp_pkg;

    // Self-programming operations issued by the CPU side
    typedef enum logic [2:0] {
        OP_BUF   = 3'h0,
        OP_ERASE = 3'h1,
        OP_WRITE = 3'h2,
        OP_LOCK  = 3'h3,
        OP_LOAD  = 3'h4
    } fspp_op_t;

    // Lock byte layout, same order as the lock-set data byte
    localparam int LB1_POS     = 0;
    localparam int LB2_POS     = 1;
    localparam int APP_LO_POS  = 2;
    localparam int APP_HI_POS  = 3;
    localparam int BOOT_LO_POS = 4;
    localparam int BOOT_HI_POS = 5;

    // Reset values: locks, fuse and flash unprogrammed; application reset address zero
    localparam logic [5:0]  LOCK_RST       = 6'h3F;
    localparam logic        FUSE_RST       = 1'h1;
    localparam logic [15:0] ERASED_WORD    = 16'hFFFF;
    localparam logic [15:0] APP_RESET_ADDR = 16'h0000;

    // Page erase / page write time
    localparam int CLK_PERIOD_NS = 20;
    localparam int PROG_TIME_NS  = 100;
    localparam int PROG_CYC      = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROG_CW       = $clog2(PROG_CYC + 1);

    // Controller register offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_PTR    = 8'h04;
    localparam logic [7:0] OFS_DATA   = 8'h08;
    localparam logic [7:0] OFS_MODE   = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_RESETV = 8'h14;

    // Controller field positions
    localparam int CTRL_GO_POS   = 8;
    localparam int MODE_EXEC_POS = 0;
    localparam int MODE_IVEC_POS = 1;
    localparam int ST_BUSY_POS   = 0;
    localparam int ST_DEN_POS    = 1;
    localparam int ST_DONE_POS   = 2;
    localparam int ST_IRQ_POS    = 3;
    localparam int ST_PBUSY_POS  = 4;
    localparam int ST_RDATA_POS  = 8;

endpackage

// File: design/fspp_prot_decode.sv
`timescale 1ns/100ps
// Decodes one two-bit protection field (1 = unprogrammed)
module fspp_prot_decode (
    input  wire logic hi,
    input  wire logic lo,
    output logic      wr_block,
    output logic      rd_block,
    output logic      irq_mode
);
    // 11 free, 10 no store, 00 no store and no load, 01 no load
    assign wr_block = ~lo;  // see R4 see R6 see R8
    assign rd_block = ~hi;  // see R4 see R6
    assign irq_mode = ~hi;  // Modes 3 and 4, see R5 see R7
endmodule

// File: test/fspp_asserts.sv
`timescale 1ns/100ps
// Watches the link between the controller and the protection block
module fspp_asserts
    import fspp_pkg::*;
#(
    parameter int PW        = 3,
    parameter int BOOT_PAGE = 6
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        req_valid,
    input wire logic        req_ready,
    input wire fspp_op_t    op,
    input wire logic        exec_boot,
    input wire logic        ivec_boot,
    input wire logic        done,
    input wire logic        denied,
    input wire logic [7:0]  rdata,
    input wire logic        irq_block,
    input wire logic        prog_busy,
    input wire logic [15:0] reset_vec
);
    localparam logic [15:0] BOOT_VEC = 16'(BOOT_PAGE << PW);

    // Request accepted at this edge
    wire take = req_valid && req_ready;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // App-side stores are refused
    a_store_from_app: assert property (take && op != OP_LOAD && !exec_boot |=> done && denied)
        else $error("app store allowed");
    // Erase/write refuse at once or run full time
    a_prog_time: assert property (take && (op == OP_ERASE || op == OP_WRITE) |=>
        (done && denied) or (prog_busy [*5] ##1 (done && !denied)))
        else $error("programming time wrong");
    a_quick_answer: assert property (take && op inside {OP_BUF, OP_LOCK, OP_LOAD} |=> done && !prog_busy)
        else $error("short op late");
    a_load_zero: assert property (done && denied && op == OP_LOAD |-> rdata == 8'h00)
        else $error("blocked load data");
    a_rdata_hold: assert property ($changed(rdata) |-> done)
        else $error("rdata moved without done");
    a_reset_vector: assert property (reset_vec == 16'h0000 || reset_vec == BOOT_VEC)
        else $error("bad reset vector");
    a_irq_away: assert property (irq_block |-> $past(exec_boot) != $past(ivec_boot))
        else $error("irq masked beside vectors");
    a_busy_not_ready: assert property (prog_busy |-> !req_ready)
        else $error("ready while busy");
    a_done_ready: assert property (done |-> req_ready && !prog_busy)
        else $error("done while busy");
    // Request held until taken
    a_req_held: assert property (req_valid && !req_ready |=> req_valid && $stable(op))
        else $error("request not held");

    c_erase: cover property (take && op == OP_ERASE);
    c_denied: cover property (done && denied);
    c_load: cover property (done && !denied && op == OP_LOAD);
    c_irq: cover property (irq_block);
endmodule

// File: test/tb_top.sv
`timescale 1ns/100ps
// APB and pin stimulus, checks on both ends
module tb_top;
    import fspp_pkg::*;
    localparam int PW = 3;
    localparam int BOOT_PAGE = 6;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r, st;
    logic        ext_lock_we, ext_fuse_we, ext_fuse_data, chip_erase, boot_reset_fuse;
    logic [5:0]  ext_lock_data, lock_bits, d;
    int          errors, comparisons;
    // All field modes, plus general locks alone
    logic [5:0]  lock_tab [8] = '{6'h3F, 6'h3C, 6'h3B, 6'h33, 6'h37, 6'h2F, 6'h0F, 6'h1F};

    fspp_if lnk();
    fspp_device #(.PW(PW), .PGB(3), .BOOT_PAGE(BOOT_PAGE)) i_fspp_device (.pclk(pclk), .presetn(presetn),
        .lnk(lnk), .ext_lock_we(ext_lock_we), .ext_lock_data(ext_lock_data), .ext_fuse_we(ext_fuse_we),
        .ext_fuse_data(ext_fuse_data), .chip_erase(chip_erase), .lock_bits(lock_bits),
        .boot_reset_fuse(boot_reset_fuse));
    fspp_host i_fspp_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(lnk));
    fspp_asserts #(.PW(PW), .BOOT_PAGE(BOOT_PAGE)) i_fspp_asserts (.pclk(pclk), .presetn(presetn),
        .req_valid(lnk.req_valid), .req_ready(lnk.req_ready), .op(lnk.op), .exec_boot(lnk.exec_boot),
        .ivec_boot(lnk.ivec_boot), .done(lnk.done), .denied(lnk.denied), .rdata(lnk.rdata),
        .irq_block(lnk.irq_block), .prog_busy(lnk.prog_busy), .reset_vec(lnk.reset_vec));

    // Clock at 50 MHz
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic give_verdict;
        $display("comparisons=%0d errors=%0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer after an idle edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            errors++;
            give_verdict();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd, r, e);
    endtask

    // Issue one operation, move the pointer to another page, poll until idle
    task automatic op(input logic [2:0] code, input logic [15:0] ptr, input logic [15:0] wd);
        int n;
        wr(OFS_PTR, {16'h0000, ptr});
        wr(OFS_DATA, {16'h0000, wd});
        wr(OFS_CTRL, (32'h1 << CTRL_GO_POS) | 32'(code));
        wr(OFS_PTR, {16'h0000, ptr ^ 16'(1 << (PW + 1))});
        n = 0;
        do begin
            apb(1'b0, OFS_STATUS, 32'h0, st, e);
            n++;
        end while (st[ST_BUSY_POS] !== 1'b0 && n < 30);
        if (st[ST_BUSY_POS] !== 1'b0) begin
            errors++;
            give_verdict();
        end
    endtask

    // Operation with known refusal and load byte
    task automatic op_chk(input logic [2:0] code, input logic [15:0] ptr, input logic den, input logic [7:0] b);
        op(code, ptr, 16'h5A5A);
        chk(32'(st[ST_DEN_POS]), 32'(den));
        if (code == OP_LOAD) chk(32'(st[15:8]), 32'(b));
    endtask

    task automatic mode(input logic ex, input logic iv);
        wr(OFS_MODE, {30'h0, iv, ex});
    endtask

    task automatic erase_chip;
        @(posedge pclk) chip_erase <= 1'b1;
        @(posedge pclk) chip_erase <= 1'b0;
    endtask

    // Pointer for page, word and byte
    function automatic logic [15:0] za(input int p, input int w, input int b);
        return 16'((p << (PW + 1)) | (w << 1) | b);
    endfunction

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {ext_lock_we, ext_fuse_we, chip_erase} = '0;
        ext_lock_data = 6'h3F;
        ext_fuse_data = 1'b1;
        errors = 0;
        comparisons = 0;
        presetn = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFS_RESETV, 32'h0, r, e);
        chk(r, 32'h0000_0000);
        apb(1'b0, 8'h18, 32'h0, r, e);
        chk({r[30:0], e}, 32'h1);
        op_chk(OP_BUF, za(2, 3, 0), 1'b1, 8'h00);
        $display("test reset and refusal done");
        // Out-of-order buffer, erase and write one page
        mode(1'b1, 1'b0);
        op(OP_BUF, za(2, 3, 0), 16'h1234);
        op(OP_BUF, za(2, 1, 0), 16'hABCD);
        op_chk(OP_ERASE, za(2, 0, 0), 1'b0, 8'h00);
        op_chk(OP_WRITE, za(2, 0, 0), 1'b0, 8'h00);
        op_chk(OP_LOAD, za(2, 3, 0), 1'b0, 8'h34);
        op_chk(OP_LOAD, za(2, 3, 1), 1'b0, 8'h12);
        op_chk(OP_LOAD, za(2, 1, 1), 1'b0, 8'hAB);
        op_chk(OP_LOAD, za(2, 2, 0), 1'b0, 8'hFF);
        $display("test page program done");
        // Each lock setting: stores, loads, masking
        foreach (lock_tab[i]) begin
            d = lock_tab[i];
            erase_chip();
            mode(1'b1, 1'b0);
            op(OP_BUF, za(2, 3, 0), 16'h1234);
            op(OP_WRITE, za(2, 0, 0), 16'h0000);
            op(OP_BUF, za(6, 3, 0), 16'h1234);
            op(OP_WRITE, za(6, 0, 0), 16'h0000);
            @(posedge pclk) begin ext_lock_data <= d; ext_lock_we <= 1'b1; end
            @(posedge pclk) ext_lock_we <= 1'b0;
            @(posedge pclk) chk(32'(lock_bits), 32'(d));
            mode(1'b1, 1'b1);
            op_chk(OP_ERASE, za(2, 0, 0), !d[2], 8'h00);
            op_chk(OP_ERASE, za(6, 0, 0), !d[4], 8'h00);
            op_chk(OP_LOAD, za(2, 3, 0), !d[3], d[3] ? (d[2] ? 8'hFF : 8'h34) : 8'h00);
            mode(1'b0, 1'b1);
            apb(1'b0, OFS_STATUS, 32'h0, st, e);
            chk(32'(st[ST_IRQ_POS]), 32'(!d[3]));
            op_chk(OP_LOAD, za(6, 3, 1), !d[5], d[5] ? (d[4] ? 8'hFF : 8'h12) : 8'h00);
            mode(1'b1, 1'b0);
            apb(1'b0, OFS_STATUS, 32'h0, st, e);
            chk(32'(st[ST_IRQ_POS]), 32'(!d[5]));
        end
        $display("test lock modes done");
        // Software lock set: no pointer, no clearing
        erase_chip();
        op(OP_LOCK, 16'hFFFF, 16'h0033);
        chk(32'(lock_bits), 32'h33);
        op(OP_LOCK, 16'h1234, 16'h003F);
        chk(32'(lock_bits), 32'h33);
        erase_chip();
        @(posedge pclk) chk(32'(lock_bits), 32'h3F);
        $display("test software lock set done");
        // Programmed fuse moves reset vector
        @(posedge pclk) begin ext_fuse_data <= 1'b0; ext_fuse_we <= 1'b1; end
        @(posedge pclk) ext_fuse_we <= 1'b0;
        apb(1'b0, OFS_RESETV, 32'h0, r, e);
        chk(r, 32'(BOOT_PAGE << PW));
        $display("test fuse done");
        give_verdict();
    end
endmodule
